// [inc/flash_prot_pkg.sv]
// Constants and types for the flash and EEPROM protection configuration block
// How it works
// - EEPROM read lock bit 7 at byte 300009h: 0 locks data EEPROM reads.
// - Boot read lock bit 6 there: 0 locks program reads of 000000-0007FFh; table reads there are not locked.
// - Unimplemented configuration bit positions always read back as zero.
// - Byte 30000Ah bits 0-7 gate writes to program blocks 0-7.
// - Blocks 1 to 7 are consecutive 16-Kbyte regions up to 01FFFFh.
// - Block 0 starts at 000800, 001000 or 002000 and ends 003FFFh.
// - Boot size select: 00 is 1K words, 01 is 2K, 1x is 4K.
// - EEPROM write lock bit 7 at byte 30000Bh: 0 blocks EEPROM writes.
// - Boot write lock bit 6 there: 0 blocks writes to the boot region.
// - Config write lock bit 5: 0 blocks writes to 300000-3000FFh.
// - Config write lock bit changes only while programming mode is active.
// - Byte 30000Ch bits 0-7 refuse foreign table reads of blocks 0-7.
package flash_prot_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses on the register bus
  // ---------------------------------------------------------------
  localparam int unsigned AXI_AW = 24;
  localparam int unsigned MEM_AW = 22;

  localparam logic [21:0] CODE_PROTECT_HIGH_IDX    = 22'h300009;
  localparam logic [21:0] BLOCK_WRITE_PROTECT_IDX  = 22'h30000A;
  localparam logic [21:0] SPECIAL_WRITE_PROTECT_IDX = 22'h30000B;
  localparam logic [21:0] TABLE_READ_PROTECT_IDX   = 22'h30000C;
  localparam logic [21:0] BOOT_SIZE_CFG_IDX        = 22'h300006;

  localparam logic [23:0] CODE_PROTECT_HIGH_ADDR   =
    {CODE_PROTECT_HIGH_IDX, 2'b00};
  localparam logic [23:0] BLOCK_WRITE_PROTECT_ADDR =
    {BLOCK_WRITE_PROTECT_IDX, 2'b00};
  localparam logic [23:0] SPECIAL_WRITE_PROTECT_ADDR =
    {SPECIAL_WRITE_PROTECT_IDX, 2'b00};
  localparam logic [23:0] TABLE_READ_PROTECT_ADDR  =
    {TABLE_READ_PROTECT_IDX, 2'b00};
  localparam logic [23:0] BOOT_SIZE_CFG_ADDR       =
    {BOOT_SIZE_CFG_IDX, 2'b00};
  localparam logic [23:0] CTRL_ADDR                = 24'h000000;
  localparam logic [23:0] STATUS_ADDR              = 24'h000004;

  // ---------------------------------------------------------------
  // Implemented bit masks and erased values
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_PROTECT_HIGH_MASK  = 8'hC0;
  localparam logic [7:0] BLOCK_WRITE_MASK        = 8'hFF;
  localparam logic [7:0] SPECIAL_WRITE_MASK      = 8'hE0;
  localparam logic [7:0] TABLE_READ_MASK         = 8'hFF;
  localparam logic [7:0] BOOT_SIZE_MASK          = 8'h30;
  localparam logic [7:0] CODE_PROTECT_HIGH_RESET = 8'hC0;
  localparam logic [7:0] BLOCK_WRITE_RESET       = 8'hFF;
  localparam logic [7:0] SPECIAL_WRITE_RESET     = 8'hE0;
  localparam logic [7:0] TABLE_READ_RESET        = 8'hFF;
  localparam logic [7:0] BOOT_SIZE_RESET         = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned EEPROM_READ_LOCK_BIT        = 7;
  localparam int unsigned BOOT_READ_LOCK_BIT          = 6;
  localparam int unsigned EEPROM_WRITE_LOCK_BIT       = 7;
  localparam int unsigned BOOT_WRITE_LOCK_BIT         = 6;
  localparam int unsigned CONFIG_SPACE_WRITE_LOCK_BIT = 5;
  localparam int unsigned BOOT_SIZE_LSB               = 4;
  localparam int unsigned CTRL_ERASE_BIT              = 0;
  localparam int unsigned CTRL_CLEAR_COUNT_BIT        = 1;

  // ---------------------------------------------------------------
  // Memory map of the arrays
  // ---------------------------------------------------------------
  localparam logic [21:0] BOOT_END_1K      = 22'h000800;
  localparam logic [21:0] BOOT_END_2K      = 22'h001000;
  localparam logic [21:0] BOOT_END_4K      = 22'h002000;
  localparam logic [21:0] BOOT_READ_END    = 22'h000800;
  localparam logic [21:0] PROGRAM_TOP      = 22'h020000;
  localparam logic [13:0] CONFIG_PAGE      = 14'h3000;
  localparam int unsigned BLOCK_LSB        = 14;
  localparam logic [3:0]  REGION_BOOT      = 4'h8;
  localparam logic [3:0]  REGION_CONFIG    = 4'hA;
  localparam logic [3:0]  REGION_NONE      = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_TABLE_READ  = 3'b000,
    KIND_TABLE_WRITE = 3'b001,
    KIND_EE_WRITE    = 3'b011,
    KIND_EE_READ     = 3'b010,
    KIND_PROG_READ   = 3'b110
  } access_kind_e;

  typedef struct packed {
    access_kind_e kind;
    logic [21:0]  addr;
    logic [21:0]  pc;
  } access_req_s;

  typedef struct packed {
    logic       eeprom_read_lock;
    logic       boot_read_lock;
    logic       eeprom_write_lock;
    logic       boot_write_lock;
    logic       config_space_write_lock;
    logic [7:0] block_write_lock;
    logic [7:0] block_foreign_read_lock;
    logic [1:0] boot_region_size_sel;
  } prot_cfg_s;

endpackage

// [core/prot_decision.sv]
// Region decode and allow/refuse decision for one array access
`timescale 1ns/1ns
module prot_decision (
  input  flash_prot_pkg::prot_cfg_s   cfg,
  input  flash_prot_pkg::access_req_s req,
  output logic                        allow
);
  import flash_prot_pkg::*;

  logic [21:0] boot_end;
  logic [3:0]  target_region;
  logic [3:0]  code_region;

  // Region of an address; blocks 1 to 7 are 16 Kbytes each
  function automatic logic [3:0] region_of(input logic [21:0] a,
                                           input logic [21:0] bend);
    logic [3:0] r;
    r = REGION_NONE;
    if (a < bend) begin
      r = REGION_BOOT;
    end else if (a < PROGRAM_TOP) begin
      r = {1'b0, a[BLOCK_LSB+2:BLOCK_LSB]};
    end else if (a[21:8] == CONFIG_PAGE) begin
      r = REGION_CONFIG;
    end
    return r;
  endfunction

  // Boot region end, which is also where block 0 starts
  always_comb begin
    unique case (cfg.boot_region_size_sel)
      2'b00:   boot_end = BOOT_END_1K;
      2'b01:   boot_end = BOOT_END_2K;
      default: boot_end = BOOT_END_4K;
    endcase
  end

  // Block 0 runs from boot_end up to 003FFFh
  assign target_region = region_of(req.addr, boot_end);
  assign code_region   = region_of(req.pc, boot_end);

  // Decision; access outside every region is refused for writes
  always_comb begin
    allow = 1'b1;
    unique case (req.kind)
      KIND_TABLE_READ: begin
        if (!target_region[3] &&
            !cfg.block_foreign_read_lock[target_region[2:0]] &&
            code_region != target_region) begin
          allow = 1'b0;
        end
      end
      KIND_TABLE_WRITE: begin
        if (!target_region[3]) begin
          allow = cfg.block_write_lock[target_region[2:0]];
        end else if (target_region == REGION_BOOT) begin
          allow = cfg.boot_write_lock;
        end else if (target_region == REGION_CONFIG) begin
          allow = cfg.config_space_write_lock;
        end else begin
          allow = 1'b0;
        end
      end
      KIND_EE_WRITE: allow = cfg.eeprom_write_lock;
      KIND_EE_READ:  allow = cfg.eeprom_read_lock;
      KIND_PROG_READ: begin
        if (req.addr < BOOT_READ_END) begin
          allow = cfg.boot_read_lock;
        end
      end
      default: allow = 1'b0;
    endcase
  end

endmodule

// [core/flash_block_protection_config.sv]
// Protection configuration bytes, AXI4-Lite access and access checking
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
module flash_block_protection_config #(
  parameter int unsigned COUNT_W = 8
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite slave
  input  wire logic [23:0]                 s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [23:0]                 s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Programming mode strap from the external programmer
  input  wire logic                        prog_mode_pin,
  // Access check port from the core and programmer logic
  input  wire logic                        req_valid,
  input  wire flash_prot_pkg::access_req_s req,
  output logic                             resp_valid,
  output logic                             resp_allow
);
  import flash_prot_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic               prog_sync1;
  logic               prog_mode;
  logic [7:0]         cp_high;
  logic [7:0]         wr_block;
  logic [7:0]         wr_special;
  logic [7:0]         rd_block;
  logic [7:0]         boot_size;
  logic [7:0]         next_cp_high;
  logic [7:0]         next_wr_block;
  logic [7:0]         next_wr_special;
  logic [7:0]         next_rd_block;
  logic [7:0]         next_boot_size;
  logic               aw_full;
  logic               w_full;
  logic [23:0]        awaddr_q;
  logic [7:0]         wbyte_q;
  logic               wlane_q;
  logic               next_aw_full;
  logic               next_w_full;
  logic [23:0]        next_awaddr_q;
  logic [7:0]         next_wbyte_q;
  logic               next_wlane_q;
  logic               next_bvalid;
  logic [1:0]         next_bresp;
  logic               next_rvalid;
  logic [31:0]        next_rdata;
  logic [1:0]         next_rresp;
  logic [COUNT_W-1:0] refuse_count;
  logic [COUNT_W-1:0] next_refuse_count;
  logic               last_refused;
  logic               next_last_refused;
  logic               count_clear;
  logic               allow;
  prot_cfg_s          cfg;
  logic [23:0]        wr_addr;
  logic [7:0]         wr_special_new;

  // ---------------------------------------------------------------
  // Programming mode synchroniser
  // ---------------------------------------------------------------
  // Two stages, the pin is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_sync1 <= 1'b0;
      prog_mode  <= 1'b0;
    end else begin
      prog_sync1 <= prog_mode_pin;
      prog_mode  <= prog_sync1;
    end
  end

  // ---------------------------------------------------------------
  // Decoded protection settings
  // ---------------------------------------------------------------
  // Lock bit = 1 means unprotected, as stored
  always_comb begin
    cfg.eeprom_read_lock        = cp_high[EEPROM_READ_LOCK_BIT];
    cfg.boot_read_lock          = cp_high[BOOT_READ_LOCK_BIT];
    cfg.eeprom_write_lock       = wr_special[EEPROM_WRITE_LOCK_BIT];
    cfg.boot_write_lock         = wr_special[BOOT_WRITE_LOCK_BIT];
    cfg.config_space_write_lock = wr_special[CONFIG_SPACE_WRITE_LOCK_BIT];
    cfg.block_write_lock        = wr_block;
    cfg.block_foreign_read_lock = rd_block;
    cfg.boot_region_size_sel    = boot_size[BOOT_SIZE_LSB+1:BOOT_SIZE_LSB];
  end

  prot_decision u_decision (
    .cfg   (cfg),
    .req   (req),
    .allow (allow)
  );

  // ---------------------------------------------------------------
  // Write channel and configuration byte update
  // ---------------------------------------------------------------
  assign wr_addr = {awaddr_q[23:2], 2'b00};
  // Clear-only; the config lock bit keeps its value outside programming
  always_comb begin
    wr_special_new = wr_special & wbyte_q & SPECIAL_WRITE_MASK;
    if (!prog_mode) begin
      wr_special_new[CONFIG_SPACE_WRITE_LOCK_BIT] =
        wr_special[CONFIG_SPACE_WRITE_LOCK_BIT];
    end
  end

  // Address and data are captured independently, executed once both held
  always_comb begin
    next_aw_full    = aw_full;
    next_w_full     = w_full;
    next_awaddr_q   = awaddr_q;
    next_wbyte_q    = wbyte_q;
    next_wlane_q    = wlane_q;
    next_bvalid     = s_axi_bvalid;
    next_bresp      = s_axi_bresp;
    next_cp_high    = cp_high;
    next_wr_block   = wr_block;
    next_wr_special = wr_special;
    next_rd_block   = rd_block;
    next_boot_size  = boot_size;
    count_clear     = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full  = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full  = 1'b1;
      next_wbyte_q = s_axi_wdata[7:0];
      next_wlane_q = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !s_axi_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (wr_addr)
        CODE_PROTECT_HIGH_ADDR, BLOCK_WRITE_PROTECT_ADDR,
        SPECIAL_WRITE_PROTECT_ADDR, TABLE_READ_PROTECT_ADDR,
        BOOT_SIZE_CFG_ADDR: begin
          if (!cfg.config_space_write_lock) begin
            next_bresp = RESP_SLVERR;
          end else if (wlane_q) begin
            unique case (wr_addr)
              CODE_PROTECT_HIGH_ADDR:
                next_cp_high = cp_high & wbyte_q & CODE_PROTECT_HIGH_MASK;
              BLOCK_WRITE_PROTECT_ADDR:
                next_wr_block = wr_block & wbyte_q & BLOCK_WRITE_MASK;
              SPECIAL_WRITE_PROTECT_ADDR:
                next_wr_special = wr_special_new;
              TABLE_READ_PROTECT_ADDR:
                next_rd_block = rd_block & wbyte_q & TABLE_READ_MASK;
              default:
                next_boot_size = wbyte_q & BOOT_SIZE_MASK;
            endcase
          end
        end
        CTRL_ADDR: begin
          if (wlane_q && wbyte_q[CTRL_CLEAR_COUNT_BIT]) begin
            count_clear = 1'b1;
          end
          if (wlane_q && wbyte_q[CTRL_ERASE_BIT]) begin
            if (prog_mode) begin
              next_cp_high    = CODE_PROTECT_HIGH_RESET;
              next_wr_block   = BLOCK_WRITE_RESET;
              next_wr_special = SPECIAL_WRITE_RESET;
              next_rd_block   = TABLE_READ_RESET;
              next_boot_size  = BOOT_SIZE_RESET;
            end else begin
              next_bresp = RESP_SLVERR;
            end
          end
        end
        STATUS_ADDR: next_bresp = RESP_SLVERR;
        default:     next_bresp = RESP_DECERR;
      endcase
    end
  end

  // Registers for the write path; erased values after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      awaddr_q      <= 24'h000000;
      wbyte_q       <= 8'h00;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      cp_high       <= CODE_PROTECT_HIGH_RESET;
      wr_block      <= BLOCK_WRITE_RESET;
      wr_special    <= SPECIAL_WRITE_RESET;
      rd_block      <= TABLE_READ_RESET;
      boot_size     <= BOOT_SIZE_RESET;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      awaddr_q      <= next_awaddr_q;
      wbyte_q       <= next_wbyte_q;
      wlane_q       <= next_wlane_q;
      s_axi_awready <= !next_aw_full;
      s_axi_wready  <= !next_w_full;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      cp_high       <= next_cp_high;
      wr_block      <= next_wr_block;
      wr_special    <= next_wr_special;
      rd_block      <= next_rd_block;
      boot_size     <= next_boot_size;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  // Unimplemented bits are masked off at storage, so they read zero
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case ({s_axi_araddr[23:2], 2'b00})
        CODE_PROTECT_HIGH_ADDR:   next_rdata = {24'h000000, cp_high};
        BLOCK_WRITE_PROTECT_ADDR: next_rdata = {24'h000000, wr_block};
        SPECIAL_WRITE_PROTECT_ADDR:
          next_rdata = {24'h000000, wr_special};
        TABLE_READ_PROTECT_ADDR:  next_rdata = {24'h000000, rd_block};
        BOOT_SIZE_CFG_ADDR:       next_rdata = {24'h000000, boot_size};
        CTRL_ADDR:                next_rdata = 32'h00000000;
        STATUS_ADDR: begin
          next_rdata = 32'h00000000;
          next_rdata[0] = prog_mode;
          next_rdata[1] = last_refused;
          next_rdata[8 +: COUNT_W] = refuse_count;
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_DECERR;
        end
      endcase
    end
  end

  // One outstanding read; arready drops while the answer waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_arready <= !next_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // Access check answers and refusal statistics
  // ---------------------------------------------------------------
  // A refusal in the same cycle as a clear still counts
  always_comb begin
    next_refuse_count = count_clear ? '0 : refuse_count;
    next_last_refused = last_refused;
    if (req_valid) begin
      next_last_refused = !allow;
      if (!allow && next_refuse_count != {COUNT_W{1'b1}}) begin
        next_refuse_count = next_refuse_count + 1'b1;
      end
    end
  end

  // Answer registered one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid   <= 1'b0;
      resp_allow   <= 1'b0;
      refuse_count <= '0;
      last_refused <= 1'b0;
    end else begin
      resp_valid   <= req_valid;
      resp_allow   <= req_valid && allow;
      refuse_count <= next_refuse_count;
      last_refused <= next_last_refused;
    end
  end

endmodule

// [dv/flash_prot_partner.sv]
// Model of the core and programmer side of the access check port
`timescale 1ns/1ns
module flash_prot_partner
  import flash_prot_pkg::*;
(
  input  wire logic                  aclk,
  output logic                       prog_mode_pin,
  output logic                       req_valid,
  output flash_prot_pkg::access_req_s req,
  input  wire logic                  resp_valid,
  input  wire logic                  resp_allow
);
  import flash_prot_pkg::*;
  // Idle: no request, programming mode off
  initial begin
    prog_mode_pin = 1'b0;
    req_valid     = 1'b0;
    req           = '0;
  end
  // Two sync flops, so wait three edges
  task automatic set_prog(input logic v);
    @(posedge aclk);
    prog_mode_pin <= v;
    repeat (3) @(posedge aclk);
  endtask
  // One-cycle request; the answer is sampled the cycle after
  task automatic access(input access_kind_e k, input logic [21:0] a, pc,
                        output logic [1:0] g);
    @(posedge aclk);
    req_valid <= 1'b1;
    req       <= '{k, a, pc};
    @(posedge aclk);
    req_valid <= 1'b0;
    req.addr  <= ~a; // Released bus never shows a stale address
    @(posedge aclk);
    g = {resp_valid, resp_allow};
  endtask
endmodule

// [dv/flash_prot_properties.sv]
// Port-level assertions for the protection configuration block
`timescale 1ns/1ns
module flash_prot_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        req_valid,
  input wire logic        resp_valid,
  input wire logic        resp_allow
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_resp; s_wr_taken |-> ##[1:3] s_axi_bvalid; endproperty
  property p_wr_busy;
    s_wr_taken |=> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
  endproperty
  property p_chk_lat; req_valid |=> resp_valid; endproperty
  property p_chk_idle; !req_valid |=> !resp_valid && !resp_allow;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");
  a_wr_busy: assert property (p_wr_busy)
    else $error("write slot not closed");
  a_b_done: assert property (p_b_done) else $error("bvalid stuck");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_ar_busy: assert property (p_ar_busy) else $error("arready too early");
  a_r_done: assert property (p_r_done) else $error("rvalid stuck");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  a_chk_lat: assert property (p_chk_lat)
    else $error("check request unanswered");
  a_chk_idle: assert property (p_chk_idle)
    else $error("answer without request");
endmodule
bind flash_block_protection_config flash_prot_properties u_props (.*);

// [dv/flash_block_protection_config_tb.sv]
// Self-checking bench for the flash protection configuration block
`timescale 1ns/1ns
module flash_block_protection_config_tb;
  import flash_prot_pkg::*;
  localparam logic [7:0] WLK = 8'h5A;
  logic        aclk;
  logic        aresetn;
  logic [23:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, prog_mode_pin, req_valid;
  logic        resp_valid, resp_allow;
  access_req_s req;
  int          num_errors = 0;
  int          tests_run = 0;
  int          i;
  logic [21:0] base, lo, bend;
  flash_block_protection_config u_dut (.*);
  flash_prot_partner u_core (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [23:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(s_axi_bvalid && s_axi_bready)) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!(s_axi_rvalid && s_axi_rready)) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, ed}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic acc(input access_kind_e k, input logic [21:0] a, pc,
                     input logic e);
    logic [1:0] g;
    u_core.access(k, a, pc, g);
    chk("allow", {30'h0, 1'b1, e}, {30'h0, g});
  endtask
  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard, far beyond the run's length
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    complete_run;
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    aresetn       = 1'b0;
    s_axi_awaddr  = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = '0;
    s_axi_wstrb   = 4'hF;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CODE_PROTECT_HIGH_ADDR, 8'hC0, RESP_OKAY);
    rd(BLOCK_WRITE_PROTECT_ADDR, 8'hFF, RESP_OKAY);
    rd(SPECIAL_WRITE_PROTECT_ADDR, 8'hE0, RESP_OKAY);
    rd(TABLE_READ_PROTECT_ADDR, 8'hFF, RESP_OKAY);
    rd(BOOT_SIZE_CFG_ADDR, 8'h00, RESP_OKAY);
    rd(24'h000100, 8'h00, RESP_DECERR);
    wr(24'h000100, 8'h00, RESP_DECERR);
    acc(KIND_EE_WRITE, 22'h0, 22'h0, 1'b1);
    // Boot read lock covers only the fixed 2-Kbyte region
    wr(CODE_PROTECT_HIGH_ADDR, 8'h80, RESP_OKAY);
    acc(KIND_PROG_READ, 22'h0007FF, 22'h0, 1'b0);
    acc(KIND_PROG_READ, 22'h000800, 22'h0, 1'b1);
    acc(KIND_EE_READ, 22'h0, 22'h0, 1'b1);
    wr(CODE_PROTECT_HIGH_ADDR, 8'h00, RESP_OKAY);
    acc(KIND_EE_READ, 22'h0, 22'h0, 1'b0);
    wr(SPECIAL_WRITE_PROTECT_ADDR, 8'h20, RESP_OKAY);
    acc(KIND_EE_WRITE, 22'h0, 22'h0, 1'b0);
    // Boot end moves with every size code; 1x both mean 4K words
    for (i = 0; i < 4; i++) begin
      bend = (i == 0) ? 22'h000800 : (i == 1) ? 22'h001000 : 22'h002000;
      wr(BOOT_SIZE_CFG_ADDR, 8'(i << 4), RESP_OKAY);
      acc(KIND_TABLE_WRITE, bend - 22'h1, 22'h0, 1'b0);
      acc(KIND_TABLE_WRITE, bend, 22'h0, 1'b1);
    end
    // Only blocks 0, 2, 5 and 7 are cleared; each block is checked at both ends
    wr(BLOCK_WRITE_PROTECT_ADDR, WLK, RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      base = 22'(i) << 14;
      lo = (i == 0) ? 22'h002000 : base;
      acc(KIND_TABLE_WRITE, base | 22'h3FFF, 22'h0, WLK[i]);
      acc(KIND_TABLE_WRITE, lo, 22'h0, WLK[i]);
    end
    wr(BLOCK_WRITE_PROTECT_ADDR, 8'hFF, RESP_OKAY);
    rd(BLOCK_WRITE_PROTECT_ADDR, WLK, RESP_OKAY);
    acc(KIND_TABLE_WRITE, 22'h300000, 22'h0, 1'b1);
    wr(TABLE_READ_PROTECT_ADDR, 8'hFD, RESP_OKAY);
    acc(KIND_TABLE_READ, 22'h004000, 22'h000000, 1'b0);
    acc(KIND_TABLE_READ, 22'h004000, 22'h008000, 1'b0);
    acc(KIND_TABLE_READ, 22'h004000, 22'h007000, 1'b1);
    acc(KIND_TABLE_READ, 22'h008000, 22'h000000, 1'b1);
    // Lock change and erase need programming mode
    wr(CTRL_ADDR, 8'h01, RESP_SLVERR);
    wr(SPECIAL_WRITE_PROTECT_ADDR, 8'h00, RESP_OKAY);
    rd(SPECIAL_WRITE_PROTECT_ADDR, 8'h20, RESP_OKAY);
    u_core.set_prog(1'b1);
    wr(SPECIAL_WRITE_PROTECT_ADDR, 8'h00, RESP_OKAY);
    rd(SPECIAL_WRITE_PROTECT_ADDR, 8'h00, RESP_OKAY);
    acc(KIND_TABLE_WRITE, 22'h300000, 22'h0, 1'b0);
    wr(BLOCK_WRITE_PROTECT_ADDR, 8'h00, RESP_SLVERR);
    rd(BLOCK_WRITE_PROTECT_ADDR, WLK, RESP_OKAY);
    wr(CTRL_ADDR, 8'h01, RESP_OKAY);
    rd(SPECIAL_WRITE_PROTECT_ADDR, 8'hE0, RESP_OKAY);
    wr(STATUS_ADDR, 8'h00, RESP_SLVERR);
    wr(CTRL_ADDR, 8'h02, RESP_OKAY);
    rd(STATUS_ADDR, 8'h03, RESP_OKAY);
    complete_run;
  end
endmodule
